// [rtl/power_rail_defines.vh]
// register offsets, field positions, field widths and the mask reset value for the power rail registers
`ifndef POWER_RAIL_DEFINES_VH
`define POWER_RAIL_DEFINES_VH

`define ADDR_W 8
`define OFF_SUPPLY_STATUS 8'h30
`define OFF_CORE_LEVEL 8'h34
`define OFF_PLL_LEVEL 8'h40
`define OFF_IRQ_STATUS 8'h44
`define OFF_IRQ_MASK 8'h48

`define BIT_OSC_STABLE 24
`define BIT_PLL_GOOD 19
`define BIT_CORE_GOOD 16
`define BIT_ANALOG_ILIM 9
`define BIT_CORE_ILIM 8
`define BIT_ANALOG_SOFT 1
`define BIT_CORE_SOFT 0

`define CORE_LEVEL_W 7
`define PLL_LEVEL_W 3

`define IRQ_W 7
`define IRQ_MASK_RESET 7'h00

`endif

// [rtl/power_rail_status_level_regs.v]
// supply status, core and pll regulator level registers on classic wishbone
//
// Contract
// - status bit 24 reads 1 when the on-silicon oscillator is stable
// - status bit 19 reads 1 while the pll supply rail is good
// - status bit 16 reads 1 while the core supply rail is good
// - status bit 9 reads 1 while analog buck converter limits current
// - status bit 8 reads 1 while core buck converter limits current
// - status bit 1 reads 1 while analog buck converter is soft-starting
// - status bit 0 reads 1 while core buck converter is soft-starting
// - status register is read-only, live, with reserved bits
// - core level bits 6:0 read-write, 0.60V plus code times 10 mV
// - both level fields reset to values chosen by sampled strap pins
// - pll level bits 2:0 read-write, 0.6V plus code times 100 mV
// - core level bits 31:7 and pll level bits 31:3 reserved, read-only
`timescale 1ns/100ps
`include "power_rail_defines.vh"

module power_rail_status_level_regs #(
    parameter CORE_LEVEL_W = `CORE_LEVEL_W,
    parameter PLL_LEVEL_W = `PLL_LEVEL_W
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ADDR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // live supply status from the analogue side, asynchronous
    input wire osc_stable_i,
    input wire pll_supply_rail_good_i,
    input wire core_supply_rail_good_i,
    input wire analog_buck_converter_ilim_i,
    input wire core_buck_converter_ilim_i,
    input wire analog_buck_converter_soft_i,
    input wire core_buck_converter_soft_i,
    // strap-selected reset levels, asynchronous
    input wire [CORE_LEVEL_W-1:0] core_level_strap_i,
    input wire [PLL_LEVEL_W-1:0] pll_level_strap_i,
    // level targets to the converters
    output wire [CORE_LEVEL_W-1:0] core_level_o,
    output wire [PLL_LEVEL_W-1:0] pll_level_o,
    // interrupt
    output wire irq_o
);

    // bit of each flag in the event, mask and synchroniser vectors
    localparam EV_CORE_SOFT = 0;
    localparam EV_ANALOG_SOFT = 1;
    localparam EV_CORE_ILIM = 2;
    localparam EV_ANALOG_ILIM = 3;
    localparam EV_CORE_GOOD = 4;
    localparam EV_PLL_GOOD = 5;
    localparam EV_OSC = 6;

    // registers
    reg [CORE_LEVEL_W-1:0] core_strap_meta_ff;
    reg [CORE_LEVEL_W-1:0] core_strap_sync_ff;
    reg [PLL_LEVEL_W-1:0] pll_strap_meta_ff;
    reg [PLL_LEVEL_W-1:0] pll_strap_sync_ff;
    reg [`IRQ_W-1:0] flags_prev_ff;
    reg [CORE_LEVEL_W-1:0] core_level_ff;
    reg [PLL_LEVEL_W-1:0] pll_level_ff;
    reg strap_pending_ff;
    reg [`IRQ_W-1:0] irq_status_ff;
    reg [`IRQ_W-1:0] irq_mask_ff;
    reg [31:0] nxt_dat;

    wire [`IRQ_W-1:0] flags;
    // combinational
    wire [`IRQ_W-1:0] flags_raw;
    wire [`IRQ_W-1:0] nxt_irq_status;
    wire [31:0] core_word;
    wire [31:0] pll_word;
    wire [31:0] irq_status_word;
    wire [31:0] irq_mask_word;
    wire [31:0] status_word;
    wire [`IRQ_W-1:0] flag_change;
    wire req;
    wire wr;
    wire rd_irq;
    wire rd;
    wire lane0_wr;
    wire hit_status;
    wire hit_core;
    wire hit_pll;
    wire hit_irq_status;
    wire hit_irq_mask;
    wire wr_core;
    wire wr_pll;
    wire wr_mask;

    // flags in event bit order, oscillator at the top
    assign flags_raw = {osc_stable_i,
                        pll_supply_rail_good_i,
                        core_supply_rail_good_i,
                        analog_buck_converter_ilim_i,
                        core_buck_converter_ilim_i,
                        analog_buck_converter_soft_i,
                        core_buck_converter_soft_i};

    // two flip-flops per asynchronous flag; only the second is read
    genvar f;
    generate
        for (f = 0; f < `IRQ_W; f = f + 1) begin : g_flag_sync
            reg meta_ff;
            reg sync_ff;
            always @(posedge clk_i) begin
                meta_ff <= flags_raw[f];
                sync_ff <= meta_ff;
            end
            assign flags[f] = sync_ff;
        end
    endgenerate

    // straps are static but still cross into this clock domain
    always @(posedge clk_i) begin
        core_strap_meta_ff <= core_level_strap_i;
        core_strap_sync_ff <= core_strap_meta_ff;
        pll_strap_meta_ff <= pll_level_strap_i;
        pll_strap_sync_ff <= pll_strap_meta_ff;
    end

    // live status word; each flag sits at its own bit and every
    // reserved bit is tied to zero
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1) begin : g_status
            if (b == `BIT_OSC_STABLE) begin : g_osc
                assign status_word[b] = flags[EV_OSC];
            end else if (b == `BIT_PLL_GOOD) begin : g_pll_good
                assign status_word[b] = flags[EV_PLL_GOOD];
            end else if (b == `BIT_CORE_GOOD) begin : g_core_good
                assign status_word[b] = flags[EV_CORE_GOOD];
            end else if (b == `BIT_ANALOG_ILIM) begin : g_analog_ilim
                assign status_word[b] = flags[EV_ANALOG_ILIM];
            end else if (b == `BIT_CORE_ILIM) begin : g_core_ilim
                assign status_word[b] = flags[EV_CORE_ILIM];
            end else if (b == `BIT_ANALOG_SOFT) begin : g_analog_soft
                assign status_word[b] = flags[EV_ANALOG_SOFT];
            end else if (b == `BIT_CORE_SOFT) begin : g_core_soft
                assign status_word[b] = flags[EV_CORE_SOFT];
            end else begin : g_reserved
                assign status_word[b] = 1'b0;
            end
        end
    endgenerate

    // a request is taken while ack is low; the ack then blocks a repeat
    assign req = cyc_i & stb_i & ~ack_o;
    assign rd = req & ~we_i;
    assign wr = req & we_i;
    // every writable field sits in byte lane 0
    assign lane0_wr = wr & sel_i[0];

    // address decode
    assign hit_status = (adr_i == `OFF_SUPPLY_STATUS);
    assign hit_core = (adr_i == `OFF_CORE_LEVEL);
    assign hit_pll = (adr_i == `OFF_PLL_LEVEL);
    assign hit_irq_status = (adr_i == `OFF_IRQ_STATUS);
    assign hit_irq_mask = (adr_i == `OFF_IRQ_MASK);

    // only the level and mask registers take writes
    // reading the event register clears it
    assign rd_irq = rd & hit_irq_status;
    assign wr_core = lane0_wr & hit_core;
    assign wr_pll = lane0_wr & hit_pll;
    assign wr_mask = lane0_wr & hit_irq_mask;

    // read words, upper bits of each zero
    assign core_word = {{(32-CORE_LEVEL_W){1'b0}}, core_level_ff};
    assign pll_word = {{(32-PLL_LEVEL_W){1'b0}}, pll_level_ff};
    assign irq_status_word = {{(32-`IRQ_W){1'b0}}, irq_status_ff};
    assign irq_mask_word = {{(32-`IRQ_W){1'b0}}, irq_mask_ff};

    // ack answers every taken request one edge later, for one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // read data stands with the ack and is zero otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= nxt_dat;
        end
    end

    // read mux; unmapped offsets and writes read zero
    always @* begin
        nxt_dat = 32'h0000_0000;
        if (rd) begin
            if (hit_status) begin
                nxt_dat = status_word;
            end else if (hit_core) begin
                nxt_dat = core_word;
            end else if (hit_pll) begin
                nxt_dat = pll_word;
            end else if (hit_irq_status) begin
                nxt_dat = irq_status_word;
            end else if (hit_irq_mask) begin
                nxt_dat = irq_mask_word;
            end else begin
                nxt_dat = 32'h0000_0000;
            end
        end
    end

    // straps are taken once, on the first edge after reset, when the
    // synchroniser has long settled
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_pending_ff <= 1'b1;
        end else begin
            strap_pending_ff <= 1'b0;
        end
    end

    // core level; a write in the strap-load cycle loses to the strap
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_level_ff <= {CORE_LEVEL_W{1'b0}};
        end else if (strap_pending_ff) begin
            core_level_ff <= core_strap_sync_ff;
        end else if (wr_core) begin
            core_level_ff <= dat_i[CORE_LEVEL_W-1:0];
        end
    end

    // pll regulator level, same scheme
    always @(posedge clk_i) begin
        if (rst_i) begin
            pll_level_ff <= {PLL_LEVEL_W{1'b0}};
        end else if (strap_pending_ff) begin
            pll_level_ff <= pll_strap_sync_ff;
        end else if (wr_pll) begin
            pll_level_ff <= dat_i[PLL_LEVEL_W-1:0];
        end
    end

    assign core_level_o = core_level_ff;
    assign pll_level_o = pll_level_ff;

    // previous sample of each synchronised flag, for edge detection
    always @(posedge clk_i) begin
        if (rst_i) begin
            flags_prev_ff <= {`IRQ_W{1'b0}};
        end else begin
            flags_prev_ff <= flags;
        end
    end

    // any edge of a synchronised flag is an event
    genvar e;
    generate
        for (e = 0; e < `IRQ_W; e = e + 1) begin : g_event
            wire rise;
            wire fall;
            wire set;
            wire keep;
            assign rise = flags[e] & ~flags_prev_ff[e];
            assign fall = ~flags[e] & flags_prev_ff[e];
            assign flag_change[e] = rise | fall;
            // nothing is logged in the strap-load cycle after reset
            assign set = flag_change[e] & ~strap_pending_ff;
            // a read clears the bit, but an event in that cycle wins
            assign keep = irq_status_ff[e] & ~rd_irq;
            assign nxt_irq_status[e] = set | keep;
        end
    endgenerate

    // sticky event bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_ff <= {`IRQ_W{1'b0}};
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    // event mask, same layout as the event bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= `IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_ff <= dat_i[`IRQ_W-1:0];
        end
    end

    // level interrupt while any unmasked event is pending
    assign irq_o = |(irq_status_ff & irq_mask_ff);

endmodule

// [verif/power_rail_checker_assertions.sv]
// port-level checks for the power rail register slice
`timescale 1ns/100ps
module power_rail_checker (
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic [6:0] core_level_o, core_level_strap_i,
    input wire logic [2:0] pll_level_o, pll_level_strap_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_on_time: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_status_rsvd: assert property (ack_o && $past(adr_i) == 8'h30
        |-> !(dat_o & 32'hFEF6FCFC)) else $error("status reserved set");
    a_core_read: assert property (ack_o && !$past(we_i)
        && $past(adr_i) == 8'h34 |-> dat_o == {25'h0, core_level_o})
        else $error("core read");
    a_pll_read: assert property (ack_o && !$past(we_i)
        && $past(adr_i) == 8'h40 |-> dat_o == {29'h0, pll_level_o})
        else $error("pll read");
    a_core_write: assert property (cyc_i && stb_i && we_i && !ack_o
        && sel_i[0] && adr_i == 8'h34 |=> core_level_o == $past(dat_i[6:0]))
        else $error("core write");
    a_core_hold: assert property (!(cyc_i && stb_i && we_i
        && adr_i == 8'h34) && !$past(rst_i) |=> $stable(core_level_o))
        else $error("core level moved");
    a_strap_load: assert property ($past(rst_i) && !rst_i |=>
        core_level_o == core_level_strap_i && pll_level_o == pll_level_strap_i)
        else $error("strap load");
endmodule
bind power_rail_status_level_regs power_rail_checker u_power_rail_checker (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .adr_i, .sel_i, .dat_i,
    .dat_o, .core_level_o, .core_level_strap_i, .pll_level_o,
    .pll_level_strap_i);

// [verif/power_rail_status_level_regs_test.sv]
// self-checking bench for the power rail register slice
`timescale 1ns/100ps
module power_rail_status_level_regs_test;
    logic clk_i = 0, rst_i = 1, req = 0, we_i = 0, ack_o, irq_o;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [6:0] st = 7'h00, core_level_o;
    logic [2:0] pll_level_o;
    int num_errors = 0, checked = 0;
    int pos[7] = '{0, 1, 8, 9, 16, 19, 24};
    power_rail_status_level_regs u_power_rail_status_level_regs (
        .clk_i, .rst_i, .cyc_i(req), .stb_i(req), .we_i, .adr_i,
        .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .osc_stable_i(st[6]),
        .pll_supply_rail_good_i(st[5]), .core_supply_rail_good_i(st[4]),
        .analog_buck_converter_ilim_i(st[3]),
        .core_buck_converter_ilim_i(st[2]),
        .analog_buck_converter_soft_i(st[1]),
        .core_buck_converter_soft_i(st[0]), .core_level_strap_i(7'h46),
        .pll_level_strap_i(3'h5), .core_level_o, .pll_level_o, .irq_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one classic cycle; data and ack are seen as sampled at the edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                give_verdict;
            end
            @(posedge clk_i);
        end
        rd = dat_o;
        req <= 1'b0;
        @(posedge clk_i);
    endtask
    task t_levels;
        chk(32'(pll_level_o), 32'h5);
        wb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h46);
        // one code per 100 cycles keeps the slope at 10 mV per microsecond
        for (int c = 8'h47; c <= 8'h7F; c++) begin
            wb(1'b1, 8'h34, 32'hFFFFFF80 | c);
            repeat (97) @(posedge clk_i);
        end
        wb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h7F);
        wb(1'b1, 8'h40, 32'hFFFFFFF8);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        for (int c = 1; c <= 7; c++) wb(1'b1, 8'h40, 32'(c));
        wb(1'b1, 8'h3C, 32'hFFFFFFFF);
        wb(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        chk({22'h0, core_level_o, pll_level_o}, 32'h3FF);
    endtask
    task t_status;
        for (int i = 0; i < 7; i++) begin
            st <= 7'h01 << i;
            repeat (5) @(posedge clk_i);
            wb(1'b0, 8'h30, 32'h0);
            chk(rd, 32'h1 << pos[i]);
        end
        st <= 7'h7F;
        repeat (5) @(posedge clk_i);
        wb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h01090303);
        st <= 7'h00;
    endtask
    // only the core soft-start event is unmasked
    task t_irq;
        repeat (5) @(posedge clk_i);
        wb(1'b0, 8'h44, 32'h0);
        wb(1'b1, 8'h48, 32'h1);
        st <= 7'h02;
        repeat (5) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        st <= 7'h03;
        repeat (5) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        wb(1'b0, 8'h44, 32'h0);
        chk({rd[30:0], irq_o}, 32'h6);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_levels;
        t_status;
        t_irq;
        give_verdict;
    end
endmodule
